// File: rtl/scnid_consts.svh
/*
  Constants of the scan port: instruction codes, identification fields,
  store geometry and reset values.
  Assumes it is included by bare name after the package is compiled.
*/
`ifndef SCNID_CONSTS_SVH
`define SCNID_CONSTS_SVH

// ----------------------------------------
// Instruction register
// ----------------------------------------
`define SCNID_IR_LEN 10
`define SCNID_IR_CAPTURE 10'h001
`define SCNID_OP_EXTEST 10'h000
`define SCNID_OP_SAMPLE 10'h005
`define SCNID_OP_IDCODE 10'h006
`define SCNID_OP_CFGRD 10'h00E
`define SCNID_OP_BYPASS 10'h3FF

// ----------------------------------------
// Identification value (field values arbitrary except the fixed bit, which is one)
// ----------------------------------------
`define SCNID_ID_VERSION 4'h3
`define SCNID_ID_PART 16'h5A17
`define SCNID_ID_MAKER 11'h2C4
`define SCNID_ID_FIXED 1'h1
`define SCNID_DR_LEN 32

// ----------------------------------------
// Configuration store
// ----------------------------------------
`define SCNID_CFG_WORDS 16
`define SCNID_CFG_AW 4
`define SCNID_CFG_DW 32
`define SCNID_SECURE_RST 1'h1
`define SCNID_TLR_ONES 3'h5

`endif

// File: rtl/scnid_pkg.sv
/*
  Types of the scan port block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package scnid_pkg;

  typedef enum logic [3:0] {
    SCNID_TLR = 4'h0,
    SCNID_RTI = 4'h1,
    SCNID_SEL_DR = 4'h2,
    SCNID_CAP_DR = 4'h3,
    SCNID_SHF_DR = 4'h4,
    SCNID_EX1_DR = 4'h5,
    SCNID_PAU_DR = 4'h6,
    SCNID_EX2_DR = 4'h7,
    SCNID_UPD_DR = 4'h8,
    SCNID_SEL_IR = 4'h9,
    SCNID_CAP_IR = 4'hA,
    SCNID_SHF_IR = 4'hB,
    SCNID_EX1_IR = 4'hC,
    SCNID_PAU_IR = 4'hD,
    SCNID_EX2_IR = 4'hE,
    SCNID_UPD_IR = 4'hF
  } scnid_tap_e;

  typedef logic [9:0] scnid_ir_t;

endpackage : scnid_pkg

// File: rtl/scnid_top.sv
/*
  Scan test port with identification register, bypass and a secured
  configuration store. The tester drives tck, tms and tdi; tms and tdi
  change on the falling tck edge. sys_clk runs the store.
*/
// How it works
// - Boundary test instructions select the bypass bit
// - Identification register is thirty-two bits wide
// - Fields: version, part, maker, then fixed bit
// - Identification bit zero always reads one
// - Secure bit refuses every readback path
// - Secure bit cleared only by an erase
// - Identification instruction shifts the value out
// - Ten-bit instruction register and decoder
`timescale 1ns/10ps
`default_nettype none
`include "scnid_consts.svh"

module scnid_top import scnid_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic prog_erase,
  input wire logic prog_wr,
  input wire logic [3:0] prog_addr,
  input wire logic [31:0] prog_data,
  input wire logic prog_secure,
  input wire logic rd_req,
  input wire logic [3:0] rd_addr,
  output logic [31:0] rd_data,
  output logic rd_valid,
  output logic rd_denied,
  output logic secure
);

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  // A crossed level counts once stages two and three agree; stage one may be metastable
  function automatic logic sync_agree(input logic [2:0] s, input logic prev);
    sync_agree = (s[1] == s[2]) ? s[2] : prev;
  endfunction : sync_agree

  // ----------------------------------------
  // Configuration store (sys_clk)
  // ----------------------------------------
  logic [31:0] cfg_mem [0:`SCNID_CFG_WORDS-1];
  logic secure_q;
  logic [31:0] rd_data_q;
  logic rd_valid_q;
  logic rd_denied_q;
  logic [2:0] req_sync_q;
  logic req_seen_q;
  logic ack_tog_q;
  logic [3:0] rb_ptr_q;
  logic [31:0] rb_word_q;
  // Driven on tck further down; declared here because the store side reads it first
  logic req_tog_q;

  // Stored contents are non-volatile: no reset on the array
  // Erase wins over a write in the same cycle, since a reprogram starts from blank
  always_ff @(posedge sys_clk) begin
    if (prog_erase) begin
      for (int i = 0; i < `SCNID_CFG_WORDS; i++) begin
        cfg_mem[i] <= '0;
      end
    end else if (prog_wr) begin
      cfg_mem[prog_addr] <= prog_data;
    end
  end

  // Locked after reset until an erase proves a reprogram
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      secure_q <= `SCNID_SECURE_RST;
    end else if (prog_erase) begin
      secure_q <= 1'b0;
    end else if (prog_secure) begin
      secure_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Store read port (sys_clk)
  // ----------------------------------------
  // Refused reads still answer, with zero data, so no caller waits forever
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= 32'h0000_0000;
      rd_valid_q <= 1'b0;
      rd_denied_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_req && !secure_q;
      rd_denied_q <= rd_req && secure_q;
      if (rd_req && !secure_q) begin
        rd_data_q <= cfg_mem[rd_addr];
      end else if (rd_req) begin
        rd_data_q <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Readback word service (sys_clk)
  // ----------------------------------------
  // Readback word request from the test port
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_sync_q <= 3'h0;
      req_seen_q <= 1'b0;
    end else begin
      req_sync_q <= {req_sync_q[1:0], req_tog_q};
      req_seen_q <= sync_agree(req_sync_q, req_seen_q);
    end
  end

  // Word stays still between ack toggles so the test side can latch it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_tog_q <= 1'b0;
      rb_ptr_q <= 4'h0;
      rb_word_q <= 32'h0000_0000;
    end else if (sync_agree(req_sync_q, req_seen_q) != req_seen_q) begin
      rb_word_q <= secure_q ? 32'h0000_0000 : cfg_mem[rb_ptr_q];
      rb_ptr_q <= rb_ptr_q + 4'h1;
      ack_tog_q <= ~ack_tog_q;
    end
  end

  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign rd_denied = rd_denied_q;
  assign secure = secure_q;

  // ----------------------------------------
  // Test port state machine (tck rising)
  // ----------------------------------------
  // Five tck with tms high reach the reset state from anywhere
  scnid_tap_e tap_q;
  scnid_tap_e tap_d;

  always_comb begin
    unique case (tap_q)
      SCNID_TLR: tap_d = tms ? SCNID_TLR : SCNID_RTI;
      SCNID_RTI: tap_d = tms ? SCNID_SEL_DR : SCNID_RTI;
      SCNID_SEL_DR: tap_d = tms ? SCNID_SEL_IR : SCNID_CAP_DR;
      SCNID_CAP_DR: tap_d = tms ? SCNID_EX1_DR : SCNID_SHF_DR;
      SCNID_SHF_DR: tap_d = tms ? SCNID_EX1_DR : SCNID_SHF_DR;
      SCNID_EX1_DR: tap_d = tms ? SCNID_UPD_DR : SCNID_PAU_DR;
      SCNID_PAU_DR: tap_d = tms ? SCNID_EX2_DR : SCNID_PAU_DR;
      SCNID_EX2_DR: tap_d = tms ? SCNID_UPD_DR : SCNID_SHF_DR;
      SCNID_UPD_DR: tap_d = tms ? SCNID_SEL_DR : SCNID_RTI;
      SCNID_SEL_IR: tap_d = tms ? SCNID_TLR : SCNID_CAP_IR;
      SCNID_CAP_IR: tap_d = tms ? SCNID_EX1_IR : SCNID_SHF_IR;
      SCNID_SHF_IR: tap_d = tms ? SCNID_EX1_IR : SCNID_SHF_IR;
      SCNID_EX1_IR: tap_d = tms ? SCNID_UPD_IR : SCNID_PAU_IR;
      SCNID_PAU_IR: tap_d = tms ? SCNID_EX2_IR : SCNID_PAU_IR;
      SCNID_EX2_IR: tap_d = tms ? SCNID_UPD_IR : SCNID_SHF_IR;
      SCNID_UPD_IR: tap_d = tms ? SCNID_SEL_DR : SCNID_RTI;
    endcase
  end

  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      tap_q <= SCNID_TLR;
    end else begin
      tap_q <= tap_d;
    end
  end

  // ----------------------------------------
  // Instruction register (shift rising, update falling)
  // ----------------------------------------
  // Capture value ends in 01 so a broken chain shows at once
  scnid_ir_t ir_shift_q;
  scnid_ir_t ir_q;

  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      ir_shift_q <= `SCNID_IR_CAPTURE;
    end else if (tap_q == SCNID_CAP_IR) begin
      ir_shift_q <= `SCNID_IR_CAPTURE;
    end else if (tap_q == SCNID_SHF_IR) begin
      ir_shift_q <= {tdi, ir_shift_q[`SCNID_IR_LEN-1:1]};
    end
  end

  // Reset state selects the identification register, as is usual
  always_ff @(negedge tck or negedge reset_n) begin
    if (!reset_n) begin
      ir_q <= `SCNID_OP_IDCODE;
    end else if (tap_q == SCNID_TLR) begin
      ir_q <= `SCNID_OP_IDCODE;
    end else if (tap_q == SCNID_UPD_IR) begin
      ir_q <= ir_shift_q;
    end
  end

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  logic sel_id;
  logic sel_rb;
  logic sel_byp;

  // No boundary cells here: anything but id and readback is one bit long
  always_comb begin
    sel_id = (ir_q == `SCNID_OP_IDCODE);
    sel_rb = (ir_q == `SCNID_OP_CFGRD);
    sel_byp = !sel_id && !sel_rb;
  end

  // ----------------------------------------
  // Readback word crossing into tck
  // ----------------------------------------
  logic [2:0] ack_sync_q;
  logic ack_seen_q;
  logic [2:0] sec_sync_q;
  logic sec_tck_q;
  logic [31:0] rb_hold_q;

  // Ask for the next word at each readback update
  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      req_tog_q <= 1'b0;
    end else if (tap_q == SCNID_UPD_DR && sel_rb) begin
      req_tog_q <= ~req_tog_q;
    end
  end

  // Secure resets high on this side too, so readback stays blind until the store side is heard
  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      ack_sync_q <= 3'h0;
      ack_seen_q <= 1'b0;
      sec_sync_q <= 3'h7;
      sec_tck_q <= 1'b1;
    end else begin
      ack_sync_q <= {ack_sync_q[1:0], ack_tog_q};
      ack_seen_q <= sync_agree(ack_sync_q, ack_seen_q);
      sec_sync_q <= {sec_sync_q[1:0], secure_q};
      sec_tck_q <= sync_agree(sec_sync_q, sec_tck_q);
    end
  end

  // A capture on the loading edge still sees the older word, so a reader idles a few tck first
  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      rb_hold_q <= 32'h0000_0000;
    end else if (sync_agree(ack_sync_q, ack_seen_q) != ack_seen_q) begin
      rb_hold_q <= rb_word_q;
    end
  end

  // ----------------------------------------
  // Data register path
  // ----------------------------------------
  // Bypass captures zero, which a chain reader tells apart from the identification bit
  logic [31:0] dr_q;

  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      dr_q <= 32'h0000_0000;
    end else if (tap_q == SCNID_CAP_DR) begin
      if (sel_id) begin
        dr_q <= {`SCNID_ID_VERSION, `SCNID_ID_PART, `SCNID_ID_MAKER, `SCNID_ID_FIXED};
      end else if (sel_rb) begin
        dr_q <= sec_tck_q ? 32'h0000_0000 : rb_hold_q;
      end else begin
        dr_q <= 32'h0000_0000;
      end
    end else if (tap_q == SCNID_SHF_DR) begin
      if (sel_byp) begin
        dr_q <= {31'h0000_0000, tdi};
      end else begin
        dr_q <= {tdi, dr_q[`SCNID_DR_LEN-1:1]};
      end
    end
  end

  // ----------------------------------------
  // Serial output, changes on falling tck
  // ----------------------------------------
  // Launching on falling tck gives the far side half a period of setup
  logic tdo_q;
  logic tdo_oe_q;

  always_ff @(negedge tck or negedge reset_n) begin
    if (!reset_n) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_oe_q <= (tap_q == SCNID_SHF_DR) || (tap_q == SCNID_SHF_IR);
      tdo_q <= (tap_q == SCNID_SHF_IR) ? ir_shift_q[0] : dr_q[0];
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;

endmodule : scnid_top
`default_nettype wire

// File: verif/scnid_asserts.sv
/* Checker of the store read port and the secure bit.
   Assumes it is bound to scnid_top and sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module scnid_asserts (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic prog_erase,
  input wire logic prog_secure,
  input wire logic rd_req,
  input wire logic [31:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_denied,
  input wire logic secure
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  chk_one_answer: assert property (rd_req |=> rd_valid != rd_denied)
    else $error("read not answered exactly once");
  chk_deny_locked: assert property (rd_req && secure && !prog_erase |=> rd_denied)
    else $error("locked read not refused");
  chk_deny_zero: assert property (rd_denied |-> rd_data == 32'h0)
    else $error("refused read shows data");
  chk_grant_open: assert property (rd_req && !secure |=> rd_valid)
    else $error("open read refused");
  chk_no_spurious: assert property (!rd_req |=> !rd_valid && !rd_denied)
    else $error("answer without request");
  chk_lock_holds: assert property (secure && !prog_erase |=> secure)
    else $error("secure bit dropped without erase");
  chk_erase_clears: assert property (prog_erase |=> !secure)
    else $error("erase left secure bit set");
  chk_lock_sets: assert property (prog_secure && !prog_erase |=> secure[*2])
    else $error("secure pulse did not lock");
endmodule : scnid_asserts
`default_nettype wire

// File: verif/scnid_tester.sv
/* Scan controller model driving the test link.
   Assumes the caller steps it; tck stands low between frames. */
`timescale 1ns/10ps
`default_nettype none
module scnid_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end
  // Change after falling tck, sample tdo before rising; pulled high when not driven
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #25;
    o = tdo_oe ? tdo : 1'h1;
    tck = 1'h1;
    #23;
    tck = 1'h0;
  endtask : step
  // From idle: capture, shift n bits LSB first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic o;
    dout = 32'h0;
    step(1'h1, 1'h1, o);
    if (ir) step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
    step(1'h0, 1'h1, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
  endtask : scan
endmodule : scnid_tester
`default_nettype wire

// File: verif/scnid_top_tb.sv
/* Self-checking bench of the scan port and secured store.
   Assumes the package and constants header are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "scnid_consts.svh"
module scnid_top_tb;
  logic sys_clk, reset_n, tck, tms, tdi, tdo, tdo_oe, prog_erase, prog_wr, prog_secure, rd_req, b, sec_m;
  logic [3:0] prog_addr, rd_addr;
  logic [31:0] prog_data, rd_data, seed, got;
  logic rd_valid, rd_denied, secure;
  logic [31:0] mem [16];
  logic [32:0] exp_q [$];
  logic [9:0] ops [4] = '{`SCNID_OP_EXTEST, `SCNID_OP_SAMPLE, `SCNID_OP_BYPASS, 10'h2A5};
  int err_total, samples_checked;
  localparam logic [31:0] ID = {`SCNID_ID_VERSION, `SCNID_ID_PART, `SCNID_ID_MAKER, `SCNID_ID_FIXED};
  scnid_top scnid_top_inst (.sys_clk(sys_clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .prog_erase(prog_erase), .prog_wr(prog_wr), .prog_addr(prog_addr),
    .prog_data(prog_data), .prog_secure(prog_secure), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_denied(rd_denied), .secure(secure));
  scnid_tester scnid_tester_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic cmp(input string what, input logic [32:0] e, input logic [32:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xorshift = t ^ (t << 5);
  endfunction : xorshift
  task automatic results;
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  // Request stays high so consecutive calls are back to back
  task automatic rd(input logic [3:0] a);
    @(negedge sys_clk);
    rd_req = 1'h1;
    rd_addr = a;
    exp_q.push_back(sec_m ? {1'h1, 32'h0} : {1'h0, mem[a]});
  endtask : rd
  task automatic ctl(input logic er, input logic sc, input logic wr, input logic [3:0] a);
    @(negedge sys_clk);
    rd_req = 1'h0;
    {prog_erase, prog_secure, prog_wr, prog_addr} = {er, sc, wr, a};
    seed = xorshift(seed);
    prog_data = seed;
    if (wr) mem[a] = seed;
    sec_m = er ? 1'h0 : (sec_m | sc);
    @(negedge sys_clk);
    {prog_erase, prog_secure, prog_wr} = 3'h0;
  endtask : ctl
  always @(negedge sys_clk) begin
    if (reset_n && (rd_valid || rd_denied)) begin
      cmp("rd_result", exp_q.size() != 0 ? exp_q.pop_front() : 33'h1FFFFFFFF, {rd_denied, rd_data});
    end
  end
  initial begin
    #400000;
    err_total++;
    results();
  end
  initial begin
    {reset_n, prog_erase, prog_wr, prog_secure, rd_req, prog_addr, rd_addr, prog_data} = 0;
    {seed, sec_m, err_total, samples_checked} = {32'h4D, 1'h1, 64'h0};
    scnid_tester_inst.step(1'h1, 1'h1, b);
    scnid_tester_inst.step(1'h1, 1'h1, b);
    repeat (20) @(negedge sys_clk);
    reset_n = 1'h1;
    cmp("secure_rst", 33'h1, {32'h0, secure});
    rd(4'h3);
    rd(4'h9);
    // Drop the read request before the link runs
    ctl(1'h0, 1'h0, 1'h0, 4'h0);
    scnid_tester_inst.step(1'h0, 1'h1, b);
    scnid_tester_inst.scan(1'h0, 32, 32'hFFFFFFFF, got);
    cmp("idcode_rst", {1'h0, ID}, {1'h0, got});
    foreach (ops[i]) begin
      scnid_tester_inst.scan(1'h1, 10, {22'h0, ops[i]}, got);
      cmp("ir_capture", 33'h1, {1'h0, got});
      scnid_tester_inst.scan(1'h0, 2, 32'h3, got);
      cmp("bypass", 33'h2, {1'h0, got});
    end
    scnid_tester_inst.scan(1'h1, 10, {22'h0, `SCNID_OP_IDCODE}, got);
    scnid_tester_inst.scan(1'h0, 32, 32'h0, got);
    cmp("idcode", {1'h0, ID}, {1'h0, got});
    scnid_tester_inst.scan(1'h1, 10, {22'h0, `SCNID_OP_CFGRD}, got);
    repeat (3) begin
      scnid_tester_inst.scan(1'h0, 32, 32'hFFFFFFFF, got);
      cmp("readback", 33'h0, {1'h0, got});
    end
    ctl(1'h1, 1'h0, 1'h0, 4'h0);
    cmp("secure_erase", 33'h0, {32'h0, secure});
    for (int i = 0; i < 16; i++) ctl(1'h0, 1'h0, 1'h1, i[3:0]);
    // Three locked scans left the word pointer at 3; the first capture still holds a locked word
    for (int k = 0; k < 3; k++) begin
      repeat (4) scnid_tester_inst.step(1'h0, 1'h1, b);
      scnid_tester_inst.scan(1'h0, 32, 32'h0, got);
      cmp("readback_open", {1'h0, ((k == 0) ? 32'h0 : mem[k + 2])}, {1'h0, got});
    end
    for (int i = 0; i < 16; i++) rd(seed[i +: 4]);
    ctl(1'h0, 1'h1, 1'h1, 4'hF);
    for (int i = 0; i < 4; i++) rd(i[3:0]);
    ctl(1'h1, 1'h1, 1'h0, 4'h0);
    cmp("secure_priority", 33'h0, {32'h0, secure});
    ctl(1'h0, 1'h1, 1'h0, 4'h0);
    reset_n = 1'h0;
    repeat (3) @(negedge sys_clk);
    reset_n = 1'h1;
    cmp("secure_rerst", 33'h1, {32'h0, secure});
    repeat (3) @(negedge sys_clk);
    cmp("rd_pending", 33'h0, {1'h0, 32'(exp_q.size())});
    results();
  end
endmodule : scnid_top_tb
bind scnid_top scnid_asserts scnid_asserts_inst (.sys_clk(sys_clk), .reset_n(reset_n),
  .prog_erase(prog_erase), .prog_secure(prog_secure), .rd_req(rd_req), .rd_data(rd_data),
  .rd_valid(rd_valid), .rd_denied(rd_denied), .secure(secure));
`default_nettype wire
